// [rtl/rcd_builder.sv]
// Requester completion descriptor builder with AXI4-Lite control registers
`timescale 1ns/1ps
module rcd_builder
   import rcd_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // Parsed completion header
   input  wire logic                      cpl_valid,
   input  wire rcd_pkg::rcd_kind_e        cpl_kind,
   input  wire logic [10:0]               cpl_len,
   input  wire logic [12:0]               cpl_byte_count,
   input  wire logic [11:0]               cpl_lower_addr,
   input  wire logic                      cpl_locked,
   input  wire logic [2:0]                cpl_status,
   input  wire logic                      cpl_poison,
   input  wire logic [15:0]               cpl_req_id,
   input  wire logic [7:0]                cpl_tag,
   input  wire logic [15:0]               cpl_cpl_id,
   input  wire logic [2:0]                cpl_tc,
   input  wire logic [2:0]                cpl_attr,
   input  wire logic                      cpl_tag_unknown,
   input  wire logic                      cpl_attr_mismatch,
   input  wire logic                      cpl_addr_error,
   // Request timeout event
   input  wire logic                      tmo_valid,
   input  wire logic [7:0]                tmo_func,
   input  wire logic [7:0]                tmo_tag,
   // Descriptor out
   output logic                           desc_valid,
   output logic [rcd_pkg::RCD_DESC_W-1:0] desc,
   output logic                           irq,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [ADDR_W-1:0]         s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   import rcd_pkg::*;

   typedef enum logic [1:0] {RCD_B_IDLE = 2'b00, RCD_B_TAKE = 2'b01, RCD_B_RESP = 2'b11}
      rcd_bus_e;

   function automatic logic rcd_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      w = 8'(a);
      rcd_mapped = (w == RCD_A_CTRL) || (w == RCD_A_STAT) || (w == RCD_A_IEN) ||
                   (w == RCD_A_ICLR) || (w == RCD_A_LAST0) || (w == RCD_A_LAST1) ||
                   (w == RCD_A_LAST2) || (w == RCD_A_COUNT);
   endfunction

   rcd_bus_e              wst;
   rcd_bus_e              rst;
   logic                  enable;
   logic [RCD_NEV-1:0]    stat;
   logic [RCD_NEV-1:0]    ien;
   logic [RCD_NEV-1:0]    next_ev;
   logic [RCD_NEV-1:0]    clr;
   logic [31:0]           count;
   logic                  tmo_pend;
   logic [7:0]            tmo_pfunc;
   logic [7:0]            tmo_ptag;
   logic [3:0]            c_ec;
   logic [10:0]           c_dwc;
   logic [12:0]           c_bcnt;
   logic                  c_done;
   logic                  take_cpl;
   logic                  take_tmo;
   logic                  wr_fire;
   logic [RCD_DESC_W-1:0] next_desc;

   rcd_classify u_cls (
      .kind          (cpl_kind),
      .len           (cpl_len),
      .bc            (cpl_byte_count),
      .status        (cpl_status),
      .poison        (cpl_poison),
      .tag_unknown   (cpl_tag_unknown),
      .attr_mismatch (cpl_attr_mismatch),
      .addr_error    (cpl_addr_error),
      .ec            (c_ec),
      .dwc           (c_dwc),
      .bcnt          (c_bcnt),
      .done          (c_done)
   );

   // Completions win a collision; a timeout waits one deep in a holding slot
   assign take_cpl = enable && cpl_valid;
   assign take_tmo = enable && !cpl_valid && (tmo_pend || tmo_valid);

   always_ff @(posedge aclk) begin
      if (!aresetn)
         tmo_pend <= 1'b0;
      else if (tmo_valid && enable && cpl_valid)
         tmo_pend <= 1'b1;
      else if (take_tmo)
         tmo_pend <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmo_pfunc <= 8'h00;
         tmo_ptag  <= 8'h00;
      end else if (tmo_valid && !tmo_pend) begin
         tmo_pfunc <= tmo_func;
         tmo_ptag  <= tmo_tag;
      end
   end

   always_comb begin
      next_desc = '0;
      if (take_cpl) begin
         next_desc[RCD_LA_MSB:RCD_LA_LSB]     = cpl_lower_addr;
         next_desc[RCD_EC_MSB:RCD_EC_LSB]     = c_ec;
         next_desc[RCD_BC_MSB:RCD_BC_LSB]     = c_bcnt;
         next_desc[RCD_LOCK_BIT]              = cpl_locked;
         next_desc[RCD_DONE_BIT]              = c_done;
         next_desc[RCD_DW_MSB:RCD_DW_LSB]     = c_dwc;
         next_desc[RCD_ST_MSB:RCD_ST_LSB]     = cpl_status;
         next_desc[RCD_POI_BIT]               = cpl_poison;
         next_desc[RCD_RID_MSB:RCD_RID_LSB]   = cpl_req_id;
         next_desc[RCD_TAG_MSB:RCD_TAG_LSB]   = cpl_tag;
         next_desc[RCD_CID_MSB:RCD_CID_LSB]   = cpl_cpl_id;
         next_desc[RCD_TC_MSB:RCD_TC_LSB]     = cpl_tc;
         next_desc[RCD_ATTR_MSB:RCD_ATTR_LSB] = cpl_attr;
      end else if (take_tmo) begin
         // No packet behind a timeout, so everything else stays zero
         next_desc[RCD_EC_MSB:RCD_EC_LSB]     = RCD_EC_TIMEOUT;
         next_desc[RCD_DONE_BIT]              = 1'b1;
         next_desc[RCD_FN_MSB:RCD_RID_LSB]    = tmo_pend ? tmo_pfunc : tmo_func;
         next_desc[RCD_TAG_MSB:RCD_TAG_LSB]   = tmo_pend ? tmo_ptag : tmo_tag;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         desc_valid <= 1'b0;
         desc       <= '0;
      end else begin
         desc_valid <= take_cpl || take_tmo;
         if (take_cpl || take_tmo)
            desc <= next_desc;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         count <= 32'h0000_0000;
      else if (take_cpl || take_tmo)
         count <= count + 32'h0000_0001;
   end

   // Events, sticky status, interrupt
   assign next_ev[RCD_EV_DONE] = take_cpl && c_done;
   assign next_ev[RCD_EV_ERR]  = take_cpl && (c_ec != RCD_EC_NORMAL);
   assign next_ev[RCD_EV_TMO]  = take_tmo;
   assign wr_fire = s_axi_awvalid && s_axi_awready;

   genvar gi;
   generate
      for (gi = 0; gi < RCD_NEV; gi++) begin : g_stat
         assign clr[gi] = wr_fire && s_axi_wstrb[0] && s_axi_wdata[gi] &&
                          (8'(s_axi_awaddr) == RCD_A_ICLR);
         // A new event in the clearing cycle is kept
         always_ff @(posedge aclk) begin
            if (!aresetn)
               stat[gi] <= 1'b0;
            else if (next_ev[gi])
               stat[gi] <= 1'b1;
            else if (clr[gi])
               stat[gi] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(stat & ien);
   end

   // Write channel: both address and data must be present before taking either
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst           <= RCD_B_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RCD_OKAY;
      end else begin
         case (wst)
            RCD_B_IDLE: begin
               if (s_axi_awvalid && s_axi_wvalid) begin
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wst           <= RCD_B_TAKE;
               end
            end
            RCD_B_TAKE: begin
               s_axi_awready <= 1'b0;
               s_axi_wready  <= 1'b0;
               s_axi_bvalid  <= 1'b1;
               s_axi_bresp   <= rcd_mapped(s_axi_awaddr) ? RCD_OKAY : RCD_SLVERR;
               wst           <= RCD_B_RESP;
            end
            RCD_B_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wst          <= RCD_B_IDLE;
               end
            end
            default: wst <= RCD_B_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable <= RCD_CTRL_RST;
         ien    <= '0;
      end else if (wr_fire && s_axi_wstrb[0]) begin
         if (8'(s_axi_awaddr) == RCD_A_CTRL)
            enable <= s_axi_wdata[0];
         if (8'(s_axi_awaddr) == RCD_A_IEN)
            ien <= s_axi_wdata[RCD_NEV-1:0];
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst           <= RCD_B_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RCD_OKAY;
      end else begin
         case (rst)
            RCD_B_IDLE: begin
               if (s_axi_arvalid) begin
                  s_axi_arready <= 1'b1;
                  rst           <= RCD_B_TAKE;
               end
            end
            RCD_B_TAKE: begin
               s_axi_arready <= 1'b0;
               s_axi_rvalid  <= 1'b1;
               s_axi_rresp   <= rcd_mapped(s_axi_araddr) ? RCD_OKAY : RCD_SLVERR;
               case (8'(s_axi_araddr))
                  RCD_A_CTRL:  s_axi_rdata <= {31'h0000_0000, enable};
                  RCD_A_STAT:  s_axi_rdata <= {29'h0000_0000, stat};
                  RCD_A_IEN:   s_axi_rdata <= {29'h0000_0000, ien};
                  RCD_A_LAST0: s_axi_rdata <= desc[31:0];
                  RCD_A_LAST1: s_axi_rdata <= desc[63:32];
                  RCD_A_LAST2: s_axi_rdata <= desc[95:64];
                  RCD_A_COUNT: s_axi_rdata <= count;
                  default:     s_axi_rdata <= 32'h0000_0000;
               endcase
               rst <= RCD_B_RESP;
            end
            RCD_B_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rst          <= RCD_B_IDLE;
               end
            end
            default: rst <= RCD_B_IDLE;
         endcase
      end
   end

   // Checks
   sequence s_cpl_in;
      take_cpl;
   endsequence
   sequence s_desc_out;
      desc_valid;
   endsequence

   chk_last_only: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in and (c_ec == RCD_EC_NORMAL) and (cpl_kind == RCD_K_MEM)
      and (cpl_byte_count > {cpl_len, 2'b00}) |=> s_desc_out and !desc[RCD_DONE_BIT])
      else $error("Completed flag set on a non-final completion");
   chk_done_on_error: assert property (@(posedge aclk) disable iff (!aresetn)
      s_desc_out and (desc[RCD_EC_MSB:RCD_EC_LSB] != RCD_EC_NORMAL) |-> desc[RCD_DONE_BIT])
      else $error("Error descriptor without completed flag");
   chk_dword_range: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in and (cpl_kind == RCD_K_MEM) |=> desc[RCD_DW_MSB:RCD_DW_LSB] == $past(cpl_len)
      and desc[RCD_DW_MSB:RCD_DW_LSB] <= RCD_DW_MAX)
      else $error("Dword count wrong");
   chk_dword_io: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in and (cpl_kind == RCD_K_IO_WR) |=> desc[RCD_DW_MSB:RCD_DW_LSB] == RCD_DW_ZERO)
      else $error("I/O write Dword count not zero");
   chk_status_poison: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in |=> desc[RCD_ST_MSB:RCD_ST_LSB] == $past(cpl_status)
      and desc[RCD_POI_BIT] == $past(cpl_poison))
      else $error("Status or poison not copied");
   chk_ids_copied: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in |=> desc[RCD_RID_MSB:RCD_RID_LSB] == $past(cpl_req_id)
      and desc[RCD_TAG_MSB:RCD_TAG_LSB] == $past(cpl_tag)
      and desc[RCD_CID_MSB:RCD_CID_LSB] == $past(cpl_cpl_id))
      else $error("Identifier fields not copied");
   chk_tc_attr: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in |=> desc[RCD_TC_MSB:RCD_TC_LSB] == $past(cpl_tc)
      and desc[RCD_ATTR_MSB:RCD_ATTR_LSB] == $past(cpl_attr))
      else $error("Class or attributes not copied");
   chk_poison_code: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpl_in and cpl_poison and !cpl_tag_unknown
      |=> desc[RCD_EC_MSB:RCD_EC_LSB] == RCD_EC_POISON)
      else $error("Poisoned completion without its error code");
   chk_timeout_desc: assert property (@(posedge aclk) disable iff (!aresetn)
      take_tmo |=> desc[RCD_EC_MSB:RCD_EC_LSB] == RCD_EC_TIMEOUT and desc[RCD_DONE_BIT]
      and desc[RCD_DW_MSB:RCD_DW_LSB] == RCD_DW_ZERO)
      else $error("Timeout descriptor malformed");
   chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_desc_out |-> !desc[31] && !desc[47] && !desc[88] && !desc[95])
      else $error("Undefined descriptor bit set");
endmodule // rcd_builder

// [rtl/rcd_pkg.sv]
// Constants shared by the completion descriptor builder and its helpers
package rcd_pkg;
   // Descriptor field positions
   localparam int RCD_DESC_W   = 96;
   localparam int RCD_LA_MSB   = 11;
   localparam int RCD_LA_LSB   = 0;
   localparam int RCD_EC_MSB   = 15;
   localparam int RCD_EC_LSB   = 12;
   localparam int RCD_BC_MSB   = 28;
   localparam int RCD_BC_LSB   = 16;
   localparam int RCD_LOCK_BIT = 29;
   localparam int RCD_DONE_BIT = 30;
   localparam int RCD_DW_MSB   = 42;
   localparam int RCD_DW_LSB   = 32;
   localparam int RCD_ST_MSB   = 45;
   localparam int RCD_ST_LSB   = 43;
   localparam int RCD_POI_BIT  = 46;
   localparam int RCD_RID_MSB  = 63;
   localparam int RCD_RID_LSB  = 48;
   localparam int RCD_FN_MSB   = 55;
   localparam int RCD_TAG_MSB  = 71;
   localparam int RCD_TAG_LSB  = 64;
   localparam int RCD_CID_MSB  = 87;
   localparam int RCD_CID_LSB  = 72;
   localparam int RCD_TC_MSB   = 91;
   localparam int RCD_TC_LSB   = 89;
   localparam int RCD_ATTR_MSB = 94;
   localparam int RCD_ATTR_LSB = 92;
   // Error codes
   localparam logic [3:0] RCD_EC_NORMAL   = 4'h0;
   localparam logic [3:0] RCD_EC_POISON   = 4'h1;
   localparam logic [3:0] RCD_EC_STATUS   = 4'h2;
   localparam logic [3:0] RCD_EC_NODATA   = 4'h3;
   localparam logic [3:0] RCD_EC_MISMATCH = 4'h4;
   localparam logic [3:0] RCD_EC_ADDR     = 4'h5;
   localparam logic [3:0] RCD_EC_BADTAG   = 4'h6;
   localparam logic [3:0] RCD_EC_TIMEOUT  = 4'h9;
   // Completion status codes
   localparam logic [2:0] RCD_ST_SC  = 3'h0;
   localparam logic [2:0] RCD_ST_UR  = 3'h1;
   localparam logic [2:0] RCD_ST_CRS = 3'h2;
   localparam logic [2:0] RCD_ST_CA  = 3'h4;
   // Fixed counts for special completions
   localparam logic [10:0] RCD_DW_ONE  = 11'h001;
   localparam logic [10:0] RCD_DW_ZERO = 11'h000;
   localparam logic [10:0] RCD_DW_MAX  = 11'h400;
   localparam logic [12:0] RCD_BC_IO   = 13'h0004;
   localparam logic [12:0] RCD_BC_ZLR  = 13'h0001;
   typedef enum logic [1:0] {
      RCD_K_MEM = 2'h0, RCD_K_IO_RD = 2'h1, RCD_K_IO_WR = 2'h2, RCD_K_ZLR = 2'h3
   } rcd_kind_e;
   // Register map
   localparam logic [7:0] RCD_A_CTRL   = 8'h00;
   localparam logic [7:0] RCD_A_STAT   = 8'h04;
   localparam logic [7:0] RCD_A_IEN    = 8'h08;
   localparam logic [7:0] RCD_A_ICLR   = 8'h0C;
   localparam logic [7:0] RCD_A_LAST0  = 8'h10;
   localparam logic [7:0] RCD_A_LAST1  = 8'h14;
   localparam logic [7:0] RCD_A_LAST2  = 8'h18;
   localparam logic [7:0] RCD_A_COUNT  = 8'h1C;
   localparam int         RCD_NEV      = 3;
   localparam int         RCD_EV_DONE  = 0;
   localparam int         RCD_EV_ERR   = 1;
   localparam int         RCD_EV_TMO   = 2;
   localparam logic       RCD_CTRL_RST = 1'b1;
   localparam logic [1:0] RCD_OKAY     = 2'h0;
   localparam logic [1:0] RCD_SLVERR   = 2'h2;
endpackage

// [rtl/rcd_classify.sv]
// Completion classifier: error code, Dword count, byte count and last flag
`timescale 1ns/1ps
module rcd_classify
   import rcd_pkg::*;
(
   input  wire rcd_pkg::rcd_kind_e kind,
   input  wire logic [10:0]        len,
   input  wire logic [12:0]        bc,
   input  wire logic [2:0]         status,
   input  wire logic               poison,
   input  wire logic               tag_unknown,
   input  wire logic               attr_mismatch,
   input  wire logic               addr_error,
   output logic [3:0]              ec,
   output logic [10:0]             dwc,
   output logic [12:0]             bcnt,
   output logic                    done
);
   import rcd_pkg::*;
   always_comb begin
      case (kind)
         RCD_K_IO_RD: dwc = RCD_DW_ONE;
         RCD_K_ZLR:   dwc = RCD_DW_ONE;
         RCD_K_IO_WR: dwc = RCD_DW_ZERO;
         default:     dwc = len;
      endcase
   end

   always_comb begin
      case (kind)
         RCD_K_MEM: bcnt = bc;
         RCD_K_ZLR: bcnt = RCD_BC_ZLR;
         default:   bcnt = RCD_BC_IO;
      endcase
   end

   // Invalid tag outranks all, since nothing else can be trusted
   always_comb begin
      if (tag_unknown)
         ec = RCD_EC_BADTAG;
      else if (poison)
         ec = RCD_EC_POISON;
      else if (status != RCD_ST_SC)
         ec = RCD_EC_STATUS;
      else if (kind == RCD_K_MEM && len == RCD_DW_ZERO)
         ec = RCD_EC_NODATA;
      else if (attr_mismatch)
         ec = RCD_EC_MISMATCH;
      else if (addr_error)
         ec = RCD_EC_ADDR;
      else
         ec = RCD_EC_NORMAL;
   end

   // Last completion once the remaining bytes fit this payload, on error, or for any non-memory kind
   always_comb begin
      done = (ec != RCD_EC_NORMAL) || (kind != RCD_K_MEM)
             || (bc <= {len, 2'b00});
   end
endmodule // rcd_classify

// [tb/rcd_user_model.sv]
// Behavioural model of the user logic that consumes completion descriptors
`timescale 1ns/1ps
module rcd_user_model
   import rcd_pkg::*;
(
   input wire logic                           aclk,
   input wire logic                           desc_valid,
   input wire logic [rcd_pkg::RCD_DESC_W-1:0] desc
);
   logic [255:0] tag_busy = '0;
   logic [7:0]   cid_bus;
   logic [7:0]   cid_fn;
   int           n_bad_data = 0;
   // ARI reading of the completer identifier: bus then function
   assign cid_bus = desc[87:80];
   assign cid_fn  = desc[79:72];
   always_ff @(posedge aclk) begin
      // Tag retires only when the final descriptor of its request arrives
      if (desc_valid && desc[RCD_DONE_BIT]) begin
         tag_busy[desc[71:64]] <= 1'b0;
      end
      // Poisoned payloads are counted and discarded, never stored
      if (desc_valid && desc[RCD_POI_BIT]) begin
         n_bad_data <= n_bad_data + 1;
      end
   end
endmodule // rcd_user_model

// [tb/testbench.sv]
// Self-checking testbench for the completion descriptor builder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
   import rcd_pkg::*;
   logic aclk = 0, aresetn = 0, cpl_valid = 0, cpl_locked = 0, cpl_poison = 0, tmo_valid = 0;
   rcd_kind_e   cpl_kind = RCD_K_MEM;
   logic [10:0] cpl_len = '0;
   logic [12:0] cpl_byte_count = '0;
   logic [11:0] cpl_lower_addr = '0;
   logic [2:0]  cpl_status = '0, cpl_tc = '0, cpl_attr = '0;
   logic [15:0] cpl_req_id = '0, cpl_cpl_id = '0;
   logic [7:0]  cpl_tag = '0, tmo_func = '0, tmo_tag = '0, n = '0, awaddr = '0, araddr = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [2:0]  flg = '0, cpl_flags = '0;
   logic [31:0] wdata = '0;
   logic        desc_valid, irq, awready, wready, bvalid, arready, rvalid;
   logic [95:0] desc;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          n_fail = 0, compares = 0;
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   rcd_builder dut_u (.aclk(aclk), .aresetn(aresetn), .cpl_valid(cpl_valid),
      .cpl_kind(cpl_kind), .cpl_len(cpl_len), .cpl_byte_count(cpl_byte_count),
      .cpl_lower_addr(cpl_lower_addr), .cpl_locked(cpl_locked), .cpl_status(cpl_status),
      .cpl_poison(cpl_poison), .cpl_req_id(cpl_req_id), .cpl_tag(cpl_tag),
      .cpl_cpl_id(cpl_cpl_id), .cpl_tc(cpl_tc), .cpl_attr(cpl_attr),
      .cpl_tag_unknown(cpl_flags[0]), .cpl_attr_mismatch(cpl_flags[1]),
      .cpl_addr_error(cpl_flags[2]), .tmo_valid(tmo_valid),
      .tmo_func(tmo_func), .tmo_tag(tmo_tag), .desc_valid(desc_valid), .desc(desc), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   rcd_user_model user_u (.aclk(aclk), .desc_valid(desc_valid), .desc(desc));
   task automatic summarize;
      if (n_fail == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k = 0;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge aclk); while (!(awready && wready) && ++k < 50);
      awvalid <= 0; wvalid <= 0;
      do @(posedge aclk); while (!bvalid && ++k < 100);
      bready <= 0;
      // A stalled handshake ends the run rather than hanging it
      if (k >= 100) begin n_fail++; summarize(); end
      `CHK("bresp", er, bresp)
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k = 0;
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (!arready && ++k < 50);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid && ++k < 100);
      rready <= 0;
      if (k >= 100) begin n_fail++; summarize(); end
      `CHK("rresp", er, rresp)
      `CHK("rdata", d, rdata)
   endtask
   // Drives one completion and compares the descriptor one cycle later
   task automatic send(input rcd_kind_e k, input logic [10:0] l, input logic [12:0] b,
                       input logic [2:0] st, input logic p, input logic [3:0] ec,
                       input logic dn);
      logic [95:0] e = '0;
      n = n + 8'h01;
      cpl_valid <= 1; cpl_kind <= k; cpl_len <= l; cpl_byte_count <= b; cpl_status <= st;
      cpl_poison <= p; cpl_locked <= n[0]; cpl_lower_addr <= {4'h0, n}; cpl_tag <= n;
      cpl_req_id <= 16'ha5c3; cpl_cpl_id <= 16'h3c5a; cpl_tc <= n[2:0]; cpl_attr <= ~n[2:0];
      cpl_flags <= flg;
      e[11:0] = {4'h0, n}; e[15:12] = ec; e[29] = n[0]; e[30] = dn;
      e[28:16] = (k == RCD_K_IO_RD || k == RCD_K_IO_WR) ? 13'h0004 :
                 (k == RCD_K_ZLR) ? 13'h0001 : b;
      e[42:32] = (k == RCD_K_IO_WR) ? 11'h000 : (k == RCD_K_MEM) ? l : 11'h001;
      e[45:43] = st; e[46] = p; e[63:48] = 16'ha5c3; e[71:64] = n;
      e[87:72] = 16'h3c5a; e[91:89] = n[2:0]; e[94:92] = ~n[2:0];
      @(posedge aclk);
      cpl_valid <= 0;
      tmo_valid <= 0;
      @(posedge aclk);
      `CHK("desc_valid", 1'b1, desc_valid)
      `CHK("desc", e, desc)
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      send(RCD_K_MEM, 11'h010, 13'h00c8, RCD_ST_SC, 0, RCD_EC_NORMAL, 0);
      send(RCD_K_MEM, 11'h010, 13'h0040, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      send(RCD_K_MEM, RCD_DW_MAX, 13'h1000, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      send(RCD_K_IO_RD, 11'h001, 13'h0000, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      send(RCD_K_IO_WR, 11'h000, 13'h0000, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      send(RCD_K_ZLR, 11'h001, 13'h0000, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      send(RCD_K_MEM, 11'h000, 13'h0004, RCD_ST_UR, 0, RCD_EC_STATUS, 1);
      send(RCD_K_MEM, 11'h000, 13'h0004, RCD_ST_CRS, 0, RCD_EC_STATUS, 1);
      send(RCD_K_MEM, 11'h000, 13'h0004, RCD_ST_CA, 0, RCD_EC_STATUS, 1);
      send(RCD_K_MEM, 11'h004, 13'h0064, RCD_ST_SC, 1, RCD_EC_POISON, 1);
      flg = 3'h1;
      send(RCD_K_MEM, 11'h004, 13'h0064, RCD_ST_SC, 1, RCD_EC_BADTAG, 1);
      flg = 3'h2;
      send(RCD_K_MEM, 11'h004, 13'h0064, RCD_ST_SC, 0, RCD_EC_MISMATCH, 1);
      flg = 3'h4;
      send(RCD_K_MEM, 11'h004, 13'h0064, RCD_ST_SC, 0, RCD_EC_ADDR, 1);
      flg = 3'h0;
      send(RCD_K_MEM, 11'h000, 13'h0004, RCD_ST_SC, 0, RCD_EC_NODATA, 1);
      tmo_valid <= 1; tmo_func <= 8'h5b; tmo_tag <= 8'hc7;
      @(posedge aclk);
      tmo_valid <= 0;
      @(posedge aclk);
      `CHK("tmo_valid", 1'b1, desc_valid)
      `CHK("tmo_desc", {24'h0, 8'hc7, 8'h00, 8'h5b, 16'h0000, 32'h4000_9000}, desc)
      // Timeout beside a completion comes out one cycle late
      tmo_valid <= 1; tmo_func <= 8'h3e; tmo_tag <= 8'h81;
      send(RCD_K_MEM, 11'h002, 13'h0008, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      @(posedge aclk);
      `CHK("tmo_held", 1'b1, desc_valid)
      `CHK("tmo_held_desc", {24'h0, 8'h81, 8'h00, 8'h3e, 16'h0000, 32'h4000_9000}, desc)
      axw(RCD_A_ICLR, 32'h0000_0007, RCD_OKAY);
      axr(RCD_A_STAT, 32'h0000_0000, RCD_OKAY);
      axw(RCD_A_IEN, 32'h0000_0001, RCD_OKAY);
      send(RCD_K_MEM, 11'h002, 13'h0008, RCD_ST_SC, 0, RCD_EC_NORMAL, 1);
      repeat (2) @(posedge aclk);
      `CHK("irq", 1'b1, irq)
      axr(RCD_A_STAT, 32'h0000_0001, RCD_OKAY);
      axr(RCD_A_LAST1, 32'ha5c3_0002, RCD_OKAY);
      axw(RCD_A_ICLR, 32'h0000_0001, RCD_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("irq_clr", 1'b0, irq)
      axw(RCD_A_CTRL, 32'h0000_0000, RCD_OKAY);
      axr(RCD_A_CTRL, 32'h0000_0000, RCD_OKAY);
      // Disabled: a timeout is dropped, never held for later
      tmo_valid <= 1;
      @(posedge aclk);
      tmo_valid <= 0;
      @(posedge aclk);
      `CHK("dis_valid", 1'b0, desc_valid)
      axw(RCD_A_CTRL, 32'h0000_0001, RCD_OKAY);
      axr(RCD_A_COUNT, 32'h0000_0012, RCD_OKAY);
      `CHK("bad_data", 32'h0000_0002, user_u.n_bad_data)
      axr(8'h40, 32'h0000_0000, RCD_SLVERR);
      summarize();
   end
endmodule // testbench
